// ===== rtl/slot_hp_ctrl.sv
// Slot control and status dword of a downstream port, with hot-plug interrupt request.
// Assumes a single-cycle register port on clk_sys; slot pins are asynchronous.
//
// Overview of operation
// (RL1) Button-press event enable, bit 0, reset zero
// (RL2) Power-fault event enable, bit 1
// (RL3) Presence-change event enable, bit 3
// (RL4) Command-completed interrupt enable, bit 4
// (RL5) Bit 5 gates all hot-plug interrupts
// (RL6) Attention indicator 7:6, resets off, sends message
// (RL7) Power indicator 9:8, resets off, sends message
// (RL8) Bit 10 set requests slot power off
// (RL9) Bit 12 enables link-active change notification
// (RL10) Control reserved bits read zero, ignore writes
// (RL11) Bit 16 latches button press, write-one clears
// (RL12) Bit 17 latches power fault, write-one clears
// (RL13) Bit 18 read-only latch sensor change flag
// (RL14) Bit 19 latches presence change, write-one clears
// (RL15) Bit 20 latches command completed, write-one clears
// (RL16) Bit 21 mirrors latch sensor, one open
// (RL17) Bit 22 reads card presence, resets one
// (RL18) No slot implemented: presence reads one
// (RL19) Bit 24 set on link-active change
// (RL20) Status reserved bits read zero
// (RL21) Capability defaults loadable by side-band
// (RL22) Interrupt while enabled flag latched
// (RL23) Indicator or power write completes command
// (RL24) Event beats simultaneous write-one clear
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "slot_hp_defines.svh"
module slot_hp_ctrl
    import slot_hp_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic [11:0]  regAddr,
    input  wire logic [31:0]  regWdata,
    input  wire logic         regWrite,
    input  wire logic         regRead,
    output logic      [31:0]  regRdata,
    input  wire logic         buttonPin,
    input  wire logic         powerFaultPin,
    input  wire logic         mrlOpenPin,
    input  wire logic         presentPin,
    input  wire logic         linkActive,
    input  wire logic         capLoad,
    input  wire logic [31:0]  capLoadData,
    output logic              hotPlugIrq,
    output slot_out_type      slotOut
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [2:0]    syncButton;
        logic [2:0]    syncFault;
        logic [2:0]    syncMrl;
        logic [2:0]    syncPresent;
        slot_in_type   slotIn;
        logic          linkPrev;
        logic [15:0]   ctrl;
        logic          flagAbp;
        logic          flagPfd;
        logic          flagMrlc;
        logic          flagPdc;
        logic          flagCc;
        logic          flagDllc;
        logic [31:0]   slotCap;
        logic          slotImpl;
        logic          dllReport;
        cmd_state_type cmdState;
        logic [3:0]    cmdCount;
        logic [31:0]   rdata;
        logic          irq;
        slot_out_type  out;
    } state_type;

    state_type stateReg;
    state_type stateNext;

    // Write-one-to-clear with the event winning over the clear
    function automatic logic w1c(input logic cur, input logic ev, input logic clr);
        w1c = ev | (cur & ~clr); // [RL24]
    endfunction : w1c

    // Agreement of the second and third stage marks a settled change
    function automatic logic settled(input logic [2:0] s, input logic prev);
        settled = (s[1] == s[2]) ? s[2] : prev;
    endfunction : settled

    logic       wrSlot;
    logic       wrCfg;
    logic       evAbp;
    logic       evPfd;
    logic       evMrl;
    logic       evPdc;
    logic       evDll;
    logic       cmdDone;
    logic       presentView;
    logic [3:0] cmdCycles;
    assign cmdCycles = 4'(`CMD_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        slot_in_type nin;
        logic [15:0] wctl;
        nin       = stateReg.slotIn;
        wctl      = 16'h0000;
        stateNext = stateReg;
        wrSlot    = regWrite && (regAddr == `SLOT_CTRL_STAT_OFFSET);
        wrCfg     = regWrite && (regAddr == `HP_CFG_OFFSET);

        // Three-stage synchronisers; only the later stages are looked at
        stateNext.syncButton  = {stateReg.syncButton[1:0], buttonPin};
        stateNext.syncFault   = {stateReg.syncFault[1:0], powerFaultPin};
        stateNext.syncMrl     = {stateReg.syncMrl[1:0], mrlOpenPin};
        stateNext.syncPresent = {stateReg.syncPresent[1:0], presentPin};
        nin.button     = settled(stateReg.syncButton, stateReg.slotIn.button);
        nin.powerFault = settled(stateReg.syncFault, stateReg.slotIn.powerFault);
        nin.mrlOpen    = settled(stateReg.syncMrl, stateReg.slotIn.mrlOpen);
        nin.present    = settled(stateReg.syncPresent, stateReg.slotIn.present);
        stateNext.slotIn = nin;

        // Rising edges of button and fault, any change of latch, and any change of presence while a slot is implemented
        evAbp = nin.button & ~stateReg.slotIn.button;
        evPfd = nin.powerFault & ~stateReg.slotIn.powerFault;
        evMrl = nin.mrlOpen ^ stateReg.slotIn.mrlOpen;
        evPdc = (nin.present ^ stateReg.slotIn.present) & stateReg.slotImpl;
        evDll = stateReg.dllReport & (linkActive ^ stateReg.linkPrev); // [RL19]
        stateNext.linkPrev = linkActive;

        // Capability defaults from side-band management
        if (capLoad) begin
            stateNext.slotCap = capLoadData; // [RL21]
        end

        // Command engine: each indicator or power write is a command
        cmdDone = 1'b0;
        stateNext.out.attnMsg = 1'b0;
        stateNext.out.pwrMsg  = 1'b0;
        unique case (stateReg.cmdState)
            CMD_IDLE: begin
            end
            CMD_BUSY: begin
                if (stateReg.cmdCount == 4'h1) begin
                    cmdDone            = 1'b1; // [RL23]
                    stateNext.cmdState = CMD_IDLE;
                end
                stateNext.cmdCount = stateReg.cmdCount - 4'h1;
            end
        endcase

        if (wrSlot) begin
            // Writable control bits only; reserved stay zero
            wctl = regWdata[15:0] & 16'h17fb; // [RL10]
            stateNext.ctrl = wctl;
            stateNext.out.attnInd  = indicator_type'(wctl[`CTL_AIND_LO +: 2]); // [RL6]
            stateNext.out.pwrInd   = indicator_type'(wctl[`CTL_PIND_LO +: 2]); // [RL7]
            stateNext.out.powerOff = wctl[`CTL_PWR_OFF]; // [RL8]
            stateNext.out.attnMsg  = 1'b1; // [RL6]
            stateNext.out.pwrMsg   = 1'b1; // [RL7]
            stateNext.cmdState     = CMD_BUSY; // [RL23]
            stateNext.cmdCount     = cmdCycles;
        end
        if (wrCfg) begin
            stateNext.slotImpl  = regWdata[0];
            stateNext.dllReport = regWdata[1];
        end

        // Status flags
        stateNext.flagAbp  = w1c(stateReg.flagAbp, evAbp, wrSlot & regWdata[`ST_ABP]); // [RL11]
        stateNext.flagPfd  = w1c(stateReg.flagPfd, evPfd, wrSlot & regWdata[`ST_PFD]); // [RL12]
        stateNext.flagMrlc = stateReg.flagMrlc | evMrl; // [RL13]
        stateNext.flagPdc  = w1c(stateReg.flagPdc, evPdc, wrSlot & regWdata[`ST_PDC]); // [RL14]
        stateNext.flagCc   = w1c(stateReg.flagCc, cmdDone, wrSlot & regWdata[`ST_CC]); // [RL15]
        stateNext.flagDllc = w1c(stateReg.flagDllc, evDll, wrSlot & regWdata[`ST_DLLC]); // [RL19]

        // Interrupt request from next flags and enables
        stateNext.irq = stateNext.ctrl[`CTL_HPI_EN] & ( // [RL5] [RL22]
            (stateNext.flagAbp & stateNext.ctrl[`CTL_ABP_EN]) | // [RL1]
            (stateNext.flagPfd & stateNext.ctrl[`CTL_PFD_EN]) | // [RL2]
            (stateNext.flagPdc & stateNext.ctrl[`CTL_PDC_EN]) | // [RL3]
            (stateNext.flagCc & stateNext.ctrl[`CTL_CC_EN]) | // [RL4]
            (stateNext.flagDllc & stateNext.ctrl[`CTL_DLL_EN])); // [RL9]

        // Read data one cycle after the strobe; unmapped reads zero
        presentView = stateReg.slotImpl ? stateReg.slotIn.present : 1'b1; // [RL17] [RL18]
        stateNext.rdata = 32'h0000_0000;
        if (regRead) begin
            unique case (regAddr)
                `SLOT_CTRL_STAT_OFFSET: begin
                    stateNext.rdata[15:0]      = stateReg.ctrl;
                    stateNext.rdata[`ST_ABP]   = stateReg.flagAbp;
                    stateNext.rdata[`ST_PFD]   = stateReg.flagPfd;
                    stateNext.rdata[`ST_MRLC]  = stateReg.flagMrlc;
                    stateNext.rdata[`ST_PDC]   = stateReg.flagPdc;
                    stateNext.rdata[`ST_CC]    = stateReg.flagCc;
                    stateNext.rdata[`ST_MRL]   = stateReg.slotIn.mrlOpen; // [RL16]
                    stateNext.rdata[`ST_PDS]   = presentView;
                    stateNext.rdata[`ST_DLLC]  = stateReg.flagDllc; // [RL20]
                end
                `SLOT_CAP_OFFSET: begin
                    stateNext.rdata = stateReg.slotCap;
                end
                `HP_CFG_OFFSET: begin
                    stateNext.rdata[1:0] = {stateReg.dllReport, stateReg.slotImpl};
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stateReg               <= '0;
            stateReg.ctrl[7:6]     <= `IND_RESET; // [RL6]
            stateReg.ctrl[9:8]     <= `IND_RESET; // [RL7]
            stateReg.out.attnInd   <= IND_OFF;
            stateReg.out.pwrInd    <= IND_OFF;
            stateReg.slotIn.present <= 1'b1;
            stateReg.syncPresent   <= 3'h7;
            stateReg.slotImpl      <= 1'b1;
            stateReg.cmdState      <= CMD_IDLE;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign regRdata   = stateReg.rdata;
    assign hotPlugIrq = stateReg.irq;
    assign slotOut    = stateReg.out;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_irq_gate;
        @(posedge clk_sys) disable iff (!resetn) !stateReg.ctrl[`CTL_HPI_EN] |-> !hotPlugIrq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without master enable"); // [RL5]

    property p_irq_abp;
        @(posedge clk_sys) disable iff (!resetn)
            (stateReg.flagAbp && stateReg.ctrl[`CTL_ABP_EN] && stateReg.ctrl[`CTL_HPI_EN]) |-> hotPlugIrq;
    endproperty
    a_irq_abp: assert property (p_irq_abp) else $error("button irq missing"); // [RL22]

    property p_msg_on_write;
        @(posedge clk_sys) disable iff (!resetn)
            wrSlot |=> (slotOut.attnMsg && slotOut.pwrMsg && slotOut.attnInd == $past(regWdata[7:6]));
    endproperty
    a_msg_on_write: assert property (p_msg_on_write) else $error("indicator message missing"); // [RL6]

    property p_cc_after;
        @(posedge clk_sys) disable iff (!resetn)
            (wrSlot && !regWdata[`ST_CC]) |=> ##[4:6] stateReg.flagCc;
    endproperty
    a_cc_after: assert property (p_cc_after) else $error("command completed not set"); // [RL23]

    property p_set_wins;
        @(posedge clk_sys) disable iff (!resetn) (evAbp && wrSlot && regWdata[`ST_ABP]) |=> stateReg.flagAbp;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on clear"); // [RL24]

    property p_reserved;
        @(posedge clk_sys) disable iff (!resetn)
            $past(regRead) && $past(regAddr) == `SLOT_CTRL_STAT_OFFSET |->
            (regRdata[15:13] == 3'h0 && regRdata[11] == 1'b0 && regRdata[2] == 1'b0 && regRdata[31:25] == 7'h00
             && regRdata[23] == 1'b0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit nonzero"); // [RL10] [RL20]

    property p_no_slot_present;
        @(posedge clk_sys) disable iff (!resetn)
            ($past(regRead) && $past(regAddr) == `SLOT_CTRL_STAT_OFFSET && !$past(stateReg.slotImpl))
            |-> regRdata[`ST_PDS];
    endproperty
    a_no_slot_present: assert property (p_no_slot_present) else $error("presence not one"); // [RL18]

    property p_power;
        @(posedge clk_sys) disable iff (!resetn) wrSlot |=> slotOut.powerOff == $past(regWdata[`CTL_PWR_OFF]);
    endproperty
    a_power: assert property (p_power) else $error("power control wrong"); // [RL8]

    property p_dll_set;
        @(posedge clk_sys) disable iff (!resetn) evDll |=> stateReg.flagDllc;
    endproperty
    a_dll_set: assert property (p_dll_set) else $error("link change flag missing"); // [RL19]

    ////////////////////////////////////////////////////////////////////////////
    // Each source must reach the request on its own enable
    property p_irq_pfd;
        @(posedge clk_sys) disable iff (!resetn)
            (stateReg.flagPfd && stateReg.ctrl[`CTL_PFD_EN] && stateReg.ctrl[`CTL_HPI_EN]) |-> hotPlugIrq;
    endproperty
    a_irq_pfd: assert property (p_irq_pfd) else $error("fault irq missing"); // [RL2]

    property p_irq_pdc;
        @(posedge clk_sys) disable iff (!resetn)
            (stateReg.flagPdc && stateReg.ctrl[`CTL_PDC_EN] && stateReg.ctrl[`CTL_HPI_EN]) |-> hotPlugIrq;
    endproperty
    a_irq_pdc: assert property (p_irq_pdc) else $error("presence irq missing"); // [RL3]

    property p_irq_cc;
        @(posedge clk_sys) disable iff (!resetn)
            (stateReg.flagCc && stateReg.ctrl[`CTL_CC_EN] && stateReg.ctrl[`CTL_HPI_EN]) |-> hotPlugIrq;
    endproperty
    a_irq_cc: assert property (p_irq_cc) else $error("completion irq missing"); // [RL4]

    property p_irq_dll;
        @(posedge clk_sys) disable iff (!resetn)
            (stateReg.flagDllc && stateReg.ctrl[`CTL_DLL_EN] && stateReg.ctrl[`CTL_HPI_EN]) |-> hotPlugIrq;
    endproperty
    a_irq_dll: assert property (p_irq_dll) else $error("link irq missing"); // [RL9]

    // A request left standing after the last clear would storm the host
    property p_irq_drop;
        @(posedge clk_sys) disable iff (!resetn)
            !((stateReg.flagAbp && stateReg.ctrl[`CTL_ABP_EN]) || (stateReg.flagPfd && stateReg.ctrl[`CTL_PFD_EN])
              || (stateReg.flagPdc && stateReg.ctrl[`CTL_PDC_EN]) || (stateReg.flagCc && stateReg.ctrl[`CTL_CC_EN])
              || (stateReg.flagDllc && stateReg.ctrl[`CTL_DLL_EN])) |-> !hotPlugIrq;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq stuck after clear"); // [RL22]

    ////////////////////////////////////////////////////////////////////////////
    // Outputs toward the slot follow the written fields
    property p_pwr_ind;
        @(posedge clk_sys) disable iff (!resetn)
            wrSlot |=> (slotOut.pwrInd == $past(regWdata[9:8]));
    endproperty
    a_pwr_ind: assert property (p_pwr_ind) else $error("power indicator wrong"); // [RL7]

    // Messages are single pulses; a stray one would relight an indicator
    property p_msg_quiet;
        @(posedge clk_sys) disable iff (!resetn)
            !wrSlot |=> (!slotOut.attnMsg && !slotOut.pwrMsg);
    endproperty
    a_msg_quiet: assert property (p_msg_quiet) else $error("message without write"); // [RL6] [RL7]

    ////////////////////////////////////////////////////////////////////////////
    // Status flags: clear without event, stickiness, latch mirror
    property p_abp_clear;
        @(posedge clk_sys) disable iff (!resetn)
            (wrSlot && regWdata[`ST_ABP] && !evAbp) |=> !stateReg.flagAbp;
    endproperty
    a_abp_clear: assert property (p_abp_clear) else $error("button flag not cleared"); // [RL11]

    property p_pdc_set;
        @(posedge clk_sys) disable iff (!resetn)
            evPdc |=> stateReg.flagPdc;
    endproperty
    a_pdc_set: assert property (p_pdc_set) else $error("presence change flag missing"); // [RL14]

    // Only reset may clear the latch change flag
    property p_mrlc_sticky;
        @(posedge clk_sys) disable iff (!resetn)
            stateReg.flagMrlc |=> stateReg.flagMrlc;
    endproperty
    a_mrlc_sticky: assert property (p_mrlc_sticky) else $error("latch change flag lost"); // [RL13]

    property p_mrl_state;
        @(posedge clk_sys) disable iff (!resetn)
            ($past(regRead) && $past(regAddr) == `SLOT_CTRL_STAT_OFFSET)
            |-> regRdata[`ST_MRL] == $past(stateReg.slotIn.mrlOpen);
    endproperty
    a_mrl_state: assert property (p_mrl_state) else $error("latch state wrong"); // [RL16]

    ////////////////////////////////////////////////////////////////////////////
    // Read port: control half echoed, zero between reads
    property p_ctrl_readback;
        @(posedge clk_sys) disable iff (!resetn)
            ($past(regRead) && $past(regAddr) == `SLOT_CTRL_STAT_OFFSET) |-> regRdata[15:0] == $past(stateReg.ctrl);
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong"); // [RL1]

    property p_rdata_idle;
        @(posedge clk_sys) disable iff (!resetn)
            !$past(regRead) |-> regRdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read"); // [RL20]

    // Main scenarios reached by the bench
    c_irq: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(hotPlugIrq));
    c_cmd: cover property (@(posedge clk_sys) disable iff (!resetn) cmdDone);
    c_pdc: cover property (@(posedge clk_sys) disable iff (!resetn) evPdc);
    c_set_wins: cover property (@(posedge clk_sys) disable iff (!resetn) evAbp && wrSlot && regWdata[`ST_ABP]);
    c_dll: cover property (@(posedge clk_sys) disable iff (!resetn) evDll);
endmodule : slot_hp_ctrl

// ===== rtl/slot_hp_defines.svh
// Offsets, field positions, reset values and timing counts for the slot hot-plug register bank.
// Included by the package and the block; definitions only.
`ifndef SLOT_HP_DEFINES_SVH
`define SLOT_HP_DEFINES_SVH
`define SLOT_CTRL_STAT_OFFSET 12'h0f8
`define SLOT_CAP_OFFSET       12'h0f4
`define HP_CFG_OFFSET         12'h0fc
`define CTL_ABP_EN            0
`define CTL_PFD_EN            1
`define CTL_PDC_EN            3
`define CTL_CC_EN             4
`define CTL_HPI_EN            5
`define CTL_AIND_LO           6
`define CTL_PIND_LO           8
`define CTL_PWR_OFF           10
`define CTL_DLL_EN            12
`define ST_ABP                16
`define ST_PFD                17
`define ST_MRLC               18
`define ST_PDC                19
`define ST_CC                 20
`define ST_MRL                21
`define ST_PDS                22
`define ST_DLLC               24
`define IND_RESET             2'h3
`define CMD_TIME_NS           40
`define CLK_PERIOD_NS         8
`define CMD_CYCLES            ((`CMD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== rtl/slot_hp_pkg.sv
// Types shared by the slot hot-plug register bank.
// Assumes slot_hp_defines.svh is on the include path.
`include "slot_hp_defines.svh"
package slot_hp_pkg;
    typedef enum logic [1:0] {IND_RSVD, IND_ON, IND_BLINK, IND_OFF} indicator_type;
    typedef enum {CMD_IDLE, CMD_BUSY} cmd_state_type;
    // Slot side-band inputs after synchronising
    typedef struct packed {
        logic button;
        logic powerFault;
        logic mrlOpen;
        logic present;
    } slot_in_type;
    // Messages and power actions sent to the slot
    typedef struct packed {
        logic          attnMsg;
        indicator_type attnInd;
        logic          pwrMsg;
        indicator_type pwrInd;
        logic          powerOff;
    } slot_out_type;
endpackage : slot_hp_pkg

// ===== verif/slot_side_model.sv
// Behavioural model of the slot hardware: attention button, power fault, latch sensor and card presence.
// Assumes one-cycle request pulses from the bench on stim, driven just after a rising clk_sys edge.
`timescale 1ns/1ps
module slot_side_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] stim,
    output logic            buttonPin,
    output logic            powerFaultPin,
    output logic            mrlOpenPin,
    output logic            presentPin
);
    logic [2:0] holdCnt;

    // Latch closed, card seated at power-up
    initial begin
        buttonPin     = 1'b0;
        powerFaultPin = 1'b0;
        mrlOpenPin    = 1'b0;
        presentPin    = 1'b1;
        holdCnt       = 3'h0;
    end

    // Button and fault held several cycles so a three-stage synchroniser cannot miss them
    always @(posedge clk_sys) begin
        if (stim[1:0] != 2'h0) begin
            holdCnt       <= 3'h5;
            buttonPin     <= stim[0];
            powerFaultPin <= stim[1];
        end else if (holdCnt != 3'h0) begin
            holdCnt <= holdCnt - 3'h1;
        end else begin
            buttonPin     <= 1'b0;
            powerFaultPin <= 1'b0;
        end
        if (stim[2]) mrlOpenPin <= ~mrlOpenPin;
        if (stim[3]) presentPin <= ~presentPin;
    end
endmodule : slot_side_model

// ===== verif/testbench.sv
// Self-checking bench for the slot control and status dword.
// Assumes the register port answers reads one cycle later and the slot model sits on the pins.
`timescale 1ns/1ps
module testbench;
    import slot_hp_pkg::*;
    logic         clk_sys = 1'b0;
    logic         resetn, regWrite, regRead, linkActive, capLoad, hotPlugIrq;
    logic         rdSeen = 1'b0;
    logic [11:0]  regAddr, a;
    logic [31:0]  regWdata, regRdata, capLoadData, seed, d;
    logic [3:0]   stim;
    logic [1:0]   attnCode [3] = '{2'h1, 2'h2, 2'h3};
    logic [1:0]   pwrCode  [3] = '{2'h2, 2'h3, 2'h1};
    logic         buttonPin, powerFaultPin, mrlOpenPin, presentPin;
    slot_out_type slotOut;
    logic [31:0]  rdQ [$];
    slot_out_type outQ [$];
    int           errors = 0;
    int           comparisons = 0;

    always #4 clk_sys = ~clk_sys;

    slot_hp_ctrl u_dut (.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .buttonPin(buttonPin),
        .powerFaultPin(powerFaultPin), .mrlOpenPin(mrlOpenPin), .presentPin(presentPin),
        .linkActive(linkActive), .capLoad(capLoad), .capLoadData(capLoadData),
        .hotPlugIrq(hotPlugIrq), .slotOut(slotOut));
    slot_side_model u_slot (.clk_sys(clk_sys), .stim(stim), .buttonPin(buttonPin),
        .powerFaultPin(powerFaultPin), .mrlOpenPin(mrlOpenPin), .presentPin(presentPin));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    // Every write to the slot dword is a command: both indicator messages expected next cycle
    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr  <= adr;
        regWdata <= dat;
        if (adr == 12'h0f8) outQ.push_back({1'b1, dat[7:6], 1'b1, dat[9:8], dat[10]});
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] adr, input logic [31:0] exp);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= adr;
        rdQ.push_back(exp);
        @(posedge clk_sys);
        regRead <= 1'b0;
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    ////////////////////////////////////////////////////////////////////////////////
    // Watcher: sampled mid-cycle so the registered outputs have settled
    always @(negedge clk_sys) begin
        if (rdSeen) check("regRdata", regRdata, (rdQ.size() > 0) ? rdQ.pop_front() : 32'hdead);
        rdSeen = regRead;
        if (slotOut.attnMsg === 1'b1)
            check("slotOut", {25'h0, slotOut}, {25'h0, (outQ.size() > 0) ? outQ.pop_front() : 7'h0});
    end

    initial begin
        {resetn, regWrite, regRead, linkActive, capLoad} = 5'h0;
        {regAddr, regWdata, capLoadData, stim} = '0;
        seed = 32'd10;
        cyc(2);
        resetn <= 1'b1;
        check("slotOutReset", {25'h0, slotOut}, 32'h36);
        rd(12'h0f8, 32'h004003c0);
        rd(12'h0fc, 32'h1);
        // Unmapped places read zero and ignore writes
        for (int i = 0; i < 3; i++) begin
            d = xs();
            a = (d[11:4] == 8'h0f) ? 12'h100 : {d[11:2], 2'h0};
            wr(a, xs());
            rd(a, 32'h0);
        end
        // Indicator codes 1 to 3 once each; random enables and power bit, reserved bits must stay zero
        for (int i = 0; i < 3; i++) begin
            d = (xs() & 32'h0000fc3f) | {22'h0, pwrCode[i], attnCode[i], 6'h0};
            wr(12'h0f8, d);
            rd(12'h0f8, (d & 32'h000017fb) | 32'h00400000 | ((i > 0) ? 32'h00100000 : 32'h0));
            cyc(8);
        end
        // Command completion raises the request with both enables set, and not while its own enable is cleared
        wr(12'h0f8, 32'h001003f0);
        cyc(8);
        check("hotPlugIrq", {31'h0, hotPlugIrq}, 32'h1);
        rd(12'h0f8, 32'h005003f0);
        wr(12'h0f8, 32'h001003e0);
        cyc(8);
        check("hotPlugIrq", {31'h0, hotPlugIrq}, 32'h0);
        // Clear lands on the same edge as a new completion: flag must survive
        wr(12'h0f8, 32'h001003e0);
        cyc(3);
        wr(12'h0f8, 32'h001003e0);
        rd(12'h0f8, 32'h005003e0);
        // Slot pin events: press, fault, latch opened, card pulled
        wr(12'h0f8, 32'h011b03eb);
        @(posedge clk_sys);
        stim <= 4'hf;
        @(posedge clk_sys);
        stim <= 4'h0;
        // Button clear sampled on the very edge that latches the press: press must survive
        cyc(2);
        wr(12'h0f8, 32'h000103eb);
        cyc(8);
        rd(12'h0f8, 32'h003f03eb);
        check("hotPlugIrq", {31'h0, hotPlugIrq}, 32'h1);
        wr(12'h0f8, 32'h011f03eb);
        cyc(8);
        check("hotPlugIrq", {31'h0, hotPlugIrq}, 32'h0);
        rd(12'h0f8, 32'h003403eb);
        // Link-active change with reporting implemented
        wr(12'h0fc, 32'h3);
        wr(12'h0f8, 32'h011413e3);
        @(posedge clk_sys);
        linkActive <= 1'b1;
        cyc(8);
        rd(12'h0f8, 32'h013413e3);
        check("hotPlugIrq", {31'h0, hotPlugIrq}, 32'h1);
        // No slot behind the port: presence forced to one with the card pulled
        wr(12'h0fc, 32'h2);
        rd(12'h0f8, 32'h017413e3);
        // Capability defaults loaded over side-band
        d = xs();
        @(posedge clk_sys);
        capLoad     <= 1'b1;
        capLoadData <= d;
        @(posedge clk_sys);
        capLoad <= 1'b0;
        rd(12'h0f4, d);
        for (int i = 0; i < 20 && (rdQ.size() + outQ.size()) > 0; i++) @(posedge clk_sys);
        if ((rdQ.size() + outQ.size()) > 0) errors++;
        results();
    end

    // Hang guard
    initial begin
        #100000;
        errors++;
        results();
    end
endmodule : testbench
